// ==== logic/epc_prog_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "epc_consts.svh"

module epc_prog_ctrl
	import epc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	output logic             irq,
	output var epc_pins_s    pins,
	input  wire logic [7:0]  dataIn
);

	epc_regs_s cur;
	epc_regs_s nxt;

	assign hreadyout = cur.ready;
	assign hresp     = cur.resp;
	assign hrdata    = cur.hrdata;
	assign irq       = cur.irq;
	assign pins      = cur.pins;

	always_comb begin
		logic       addrPhase;
		logic       finish;
		logic       failNow;
		logic [1:0] setStat;
		addrPhase = hsel && htrans[1] && hready;
		finish    = 1'b0;
		failNow   = 1'b0;
		setStat   = 2'b00;
		nxt       = cur;
		nxt.ready = 1'b1;
		nxt.resp  = 1'b0;

		// Two-stage synchroniser for the data lines coming back from the device.
		nxt.sync1 = dataIn;
		nxt.sync2 = cur.sync1;

		// Address phase: latch write target, prepare read data for the data phase.
		nxt.wrPend = addrPhase && hwrite && (hsize == 3'b010);
		nxt.wrAddr = {haddr[7:2], 2'b00};
		if (addrPhase && !hwrite) begin
			unique case ({haddr[7:2], 2'b00})
				`EPC_OFF_CTRL:     nxt.hrdata = {29'h0, cur.cmd, 1'b0};
				`EPC_OFF_ADDR:     nxt.hrdata = {14'h0, cur.addrReg};
				`EPC_OFF_WDATA:    nxt.hrdata = {24'h0, cur.wdataReg};
				`EPC_OFF_RDATA:    nxt.hrdata = {24'h0, cur.rdataReg};
				`EPC_OFF_STATUS:   nxt.hrdata = {24'h0, cur.pulses, 2'b00, cur.failReg,
					cur.st != ST_IDLE};
				`EPC_OFF_IRQSTAT:  nxt.hrdata = {30'h0, cur.irqStatReg};
				`EPC_OFF_IRQMASK:  nxt.hrdata = {30'h0, cur.irqMaskReg};
				`EPC_OFF_FAILADDR: nxt.hrdata = {14'h0, cur.failAddrReg};
				default:           nxt.hrdata = 32'h0;
			endcase
		end

		// Data phase of a write.
		if (cur.wrPend) begin
			unique case (cur.wrAddr)
				`EPC_OFF_ADDR: begin
					if (cur.st == ST_IDLE) begin
						nxt.addrReg = hwdata[17:0];
					end
				end
				`EPC_OFF_WDATA: begin
					if (cur.st == ST_IDLE) begin
						nxt.wdataReg = hwdata[7:0];
					end
				end
				`EPC_OFF_IRQSTAT: nxt.irqStatReg = cur.irqStatReg & ~hwdata[1:0];
				`EPC_OFF_IRQMASK: nxt.irqMaskReg = hwdata[1:0];
				default: ;
			endcase
		end

		unique case (cur.st)
			ST_IDLE: begin
				// A start while busy is dropped because the state is not idle.
				if (cur.wrPend && cur.wrAddr == `EPC_OFF_CTRL && hwdata[`EPC_CTRL_START]) begin
					nxt.cmd               = epc_cmd_e'(hwdata[2:1]);
					nxt.failReg           = 1'b0;
					nxt.pulses            = 4'h0;
					nxt.pins.chipOnN      = 1'b0;
					nxt.pins.programPulseN = 1'b1;
					nxt.pins.addr         = nxt.addrReg;
					unique case (epc_cmd_e'(hwdata[2:1]))
						CMD_READ, CMD_VERIFY: begin
							nxt.pins.outputOnN = 1'b0;
							nxt.st             = ST_ACCESS;
							nxt.timer          = 12'(`EPC_ACCESS_CYC + 1);
						end
						CMD_PROGRAM: begin
							nxt.pins.outputOnN      = 1'b1;
							nxt.pins.dataOut        = nxt.wdataReg;
							nxt.pins.dataOe         = 1'b1;
							nxt.pins.progSupplyHigh = 1'b1;
							nxt.st                  = ST_SETTLE;
							nxt.timer               = 12'(`EPC_SETTLE_CYC - 1);
						end
						CMD_SIGNATURE: begin
							nxt.pins.addr         = {17'h0, nxt.addrReg[0]};
							nxt.pins.outputOnN    = 1'b1;
							nxt.pins.idUnlockHigh = 1'b1;
							nxt.st                = ST_SETTLE;
							nxt.timer             = 12'(`EPC_SETTLE_CYC - 1);
						end
					endcase
				end
			end
			ST_SETTLE: begin
				if (cur.timer != 12'h0) begin
					nxt.timer = cur.timer - 12'h1;
				end else if (cur.cmd == CMD_PROGRAM) begin
					nxt.pins.programPulseN = 1'b0;
					nxt.pulses             = cur.pulses + 4'h1;
					nxt.st                 = ST_PULSE;
					nxt.timer              = 12'(`EPC_PULSE_CYC - 1);
				end else begin
					nxt.pins.outputOnN = 1'b0;
					nxt.st             = ST_ACCESS;
					nxt.timer          = 12'(`EPC_ACCESS_CYC + 1);
				end
			end
			ST_PULSE: begin
				if (cur.timer != 12'h0) begin
					nxt.timer = cur.timer - 12'h1;
				end else begin
					// Data stays driven past the rising edge of the pulse.
					nxt.pins.programPulseN = 1'b1;
					nxt.st                 = ST_TURN;
					nxt.timer              = 12'(`EPC_TURN_CYC - 1);
				end
			end
			ST_TURN: begin
				if (cur.timer != 12'h0) begin
					nxt.timer = cur.timer - 12'h1;
				end else begin
					nxt.pins.dataOe    = 1'b0;
					nxt.pins.outputOnN = 1'b0;
					nxt.st             = ST_ACCESS;
					nxt.timer          = 12'(`EPC_ACCESS_CYC + 1);
				end
			end
			ST_ACCESS: begin
				// The wait covers the access time plus the two synchroniser stages.
				if (cur.timer != 12'h0) begin
					nxt.timer = cur.timer - 12'h1;
				end else begin
					nxt.rdataReg = cur.sync2;
					unique case (cur.cmd)
						CMD_READ, CMD_SIGNATURE: finish = 1'b1;
						CMD_VERIFY: begin
							finish  = 1'b1;
							failNow = cur.sync2 != cur.wdataReg;
						end
						CMD_PROGRAM: begin
							if (cur.sync2 == cur.wdataReg) begin
								finish = 1'b1;
							end else if (cur.pulses == `EPC_MAX_PULSES) begin
								finish  = 1'b1;
								failNow = 1'b1;
							end else begin
								nxt.pins.outputOnN = 1'b1;
								nxt.pins.dataOe    = 1'b1;
								nxt.st             = ST_SETTLE;
								nxt.timer          = 12'(`EPC_SETTLE_CYC - 1);
							end
						end
					endcase
				end
			end
		endcase

		if (finish) begin
			nxt.st                  = ST_IDLE;
			nxt.pins.chipOnN        = 1'b1;
			nxt.pins.outputOnN      = 1'b1;
			nxt.pins.programPulseN  = 1'b1;
			nxt.pins.dataOe         = 1'b0;
			nxt.pins.progSupplyHigh = 1'b0;
			nxt.pins.idUnlockHigh   = 1'b0;
			setStat[`EPC_IRQ_DONE]  = 1'b1;
			if (failNow) begin
				nxt.failReg            = 1'b1;
				nxt.failAddrReg        = cur.pins.addr;
				setStat[`EPC_IRQ_FAIL] = 1'b1;
			end
		end

		// Hardware set is applied after the software clear so it wins.
		nxt.irqStatReg = nxt.irqStatReg | setStat;
		nxt.irq        = |(nxt.irqStatReg & nxt.irqMaskReg);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cur                    <= '0;
			cur.pins.chipOnN       <= 1'b1;
			cur.pins.outputOnN     <= 1'b1;
			cur.pins.programPulseN <= 1'b1;
		end else begin
			cur <= nxt;
		end
	end

endmodule
`default_nettype wire

// ==== logic/epc_consts.svh ====
`ifndef EPC_CONSTS_SVH
`define EPC_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave.
`define EPC_OFF_CTRL     8'h00
`define EPC_OFF_ADDR     8'h04
`define EPC_OFF_WDATA    8'h08
`define EPC_OFF_RDATA    8'h0C
`define EPC_OFF_STATUS   8'h10
`define EPC_OFF_IRQSTAT  8'h14
`define EPC_OFF_IRQMASK  8'h18
`define EPC_OFF_FAILADDR 8'h1C

// Field positions.
`define EPC_CTRL_START   0
`define EPC_STAT_BUSY    0
`define EPC_STAT_FAIL    1
`define EPC_IRQ_DONE     0
`define EPC_IRQ_FAIL     1

// Array geometry and programming limits.
`define EPC_ADDR_W       18
`define EPC_DEPTH        262144
`define EPC_MAX_PULSES   4'hA

// Timing in nanoseconds and derived cycle counts at mclk.
`define EPC_CLK_NS       25
`define EPC_PULSE_NS     100000
`define EPC_ACCESS_NS    250
`define EPC_SETTLE_NS    2000
`define EPC_TURN_NS      100
`define EPC_PULSE_CYC    ((`EPC_PULSE_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_ACCESS_CYC   ((`EPC_ACCESS_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_SETTLE_CYC   ((`EPC_SETTLE_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)
`define EPC_TURN_CYC     ((`EPC_TURN_NS + `EPC_CLK_NS - 1) / `EPC_CLK_NS)

`endif

// ==== logic/epc_pkg.sv ====
`default_nettype none
package epc_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETTLE,
		ST_PULSE,
		ST_TURN,
		ST_ACCESS
	} epc_state_e;

	typedef enum logic [1:0] {
		CMD_READ,
		CMD_PROGRAM,
		CMD_SIGNATURE,
		CMD_VERIFY
	} epc_cmd_e;

	typedef struct packed {
		logic [17:0] addr;
		logic        chipOnN;
		logic        outputOnN;
		logic        programPulseN;
		logic [7:0]  dataOut;
		logic        dataOe;
		logic        progSupplyHigh;
		logic        idUnlockHigh;
	} epc_pins_s;

	typedef struct packed {
		epc_state_e  st;
		epc_cmd_e    cmd;
		logic [11:0] timer;
		logic [3:0]  pulses;
		logic [17:0] addrReg;
		logic [7:0]  wdataReg;
		logic [7:0]  rdataReg;
		logic [17:0] failAddrReg;
		logic        failReg;
		logic [1:0]  irqStatReg;
		logic [1:0]  irqMaskReg;
		logic [7:0]  sync1;
		logic [7:0]  sync2;
		logic        wrPend;
		logic [7:0]  wrAddr;
		logic [31:0] hrdata;
		logic        ready;
		logic        resp;
		logic        irq;
		epc_pins_s   pins;
	} epc_regs_s;

endpackage
`default_nettype wire

// ==== verification/epc_prog_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module epc_prog_ctrl_checker
	import epc_pkg::*;
(
	input wire logic      mclk,
	input wire logic      rstn,
	input wire epc_pins_s pins
);
	localparam int PULSE_CYC = 4000;
	logic [12:0] lowCnt;
	logic [3:0]  pulseCnt;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lowCnt   <= 13'h0;
			pulseCnt <= 4'h0;
		end else begin
			lowCnt   <= pins.programPulseN ? 13'h0 : lowCnt + 13'h1;
			pulseCnt <= pins.progSupplyHigh ? pulseCnt + {3'h0, $fell(pins.programPulseN)} : 4'h0;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_no_drive_clash: assert property (pins.dataOe |-> pins.outputOnN)
		else $error("data driven while output on");
	a_read_setup: assert property (!pins.outputOnN |->
		!pins.chipOnN && pins.programPulseN && !pins.dataOe)
		else $error("bad read pin levels");
	a_prog_setup: assert property ($fell(pins.programPulseN) |->
		pins.progSupplyHigh && !pins.chipOnN && pins.outputOnN && pins.dataOe)
		else $error("bad program pin levels");
	a_stable_inputs: assert property (!pins.programPulseN |->
		$stable(pins.addr) && $stable(pins.dataOut))
		else $error("address or data moved in pulse");
	a_pulse_exact: assert property ($rose(pins.programPulseN) |-> lowCnt == PULSE_CYC)
		else $error("pulse length wrong");
	a_pulse_bound: assert property (!pins.programPulseN |-> lowCnt < PULSE_CYC)
		else $error("pulse too long");
	a_read_back: assert property ($rose(pins.programPulseN) |->
		##[1:8] !pins.outputOnN && !pins.dataOe)
		else $error("no read back after pulse");
	a_pulse_limit: assert property ($fell(pins.programPulseN) |-> pulseCnt < 4'hA)
		else $error("too many pulses");
	a_ident_lines: assert property (pins.idUnlockHigh |->
		pins.addr[17:1] == 17'h0 && !pins.progSupplyHigh && pins.programPulseN)
		else $error("bad identifier pin levels");
endmodule
bind epc_prog_ctrl epc_prog_ctrl_checker epc_prog_ctrl_checker_i (.mclk(mclk), .rstn(rstn), .pins(pins));
`default_nettype wire

// ==== verification/epc_eprom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module epc_eprom_model
	import epc_pkg::*;
#(
	parameter int         ACC_NS     = 200,
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
	parameter logic [7:0] PART_CODE  = 8'hC3  // Arbitrary value.
)(
	input  wire epc_pins_s pins,
	output logic     [7:0] dataIn
);
	logic [7:0] mem [logic [17:0]];
	logic [7:0] q;
	logic [7:0] last = 8'h00;
	logic       upd  = 1'b0;
	logic       drv;
	assign drv = !pins.chipOnN && !pins.outputOnN;
	always @(pins or upd) begin
		q = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
		if (pins.idUnlockHigh) begin
			q = pins.addr[0] ? PART_CODE : MAKER_CODE;
		end
		if (drv) begin
			last = q;
		end
	end
	always @(posedge pins.programPulseN) begin
		if (pins.progSupplyHigh && !pins.chipOnN && pins.outputOnN && !pins.idUnlockHigh) begin
			mem[pins.addr] = q & pins.dataOut;
			upd = !upd;
		end
	end
	// A released bus shows the inverse of its last value, never a held copy.
	assign #ACC_NS dataIn = pins.dataOe ? pins.dataOut : drv ? q : ~last;
endmodule
`default_nettype wire

// ==== verification/epc_prog_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "epc_consts.svh"
module epc_prog_ctrl_tb
	import epc_pkg::*;
;
	localparam logic [7:0] MAKER_CODE = 8'h5A; // Arbitrary value.
	localparam logic [7:0] PART_CODE  = 8'hC3; // Arbitrary value.
	logic        mclk   = 1'b0;
	logic        rstn   = 1'b0;
	logic        hsel   = 1'b0;
	logic [31:0] haddr  = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic [31:0] hrdata;
	logic [31:0] rd;
	epc_pins_s   pins;
	logic [7:0]  dataIn;
	int          n_errors   = 0;
	int          n_compared = 0;
	epc_prog_ctrl epc_prog_ctrl_i (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .pins(pins),
		.dataIn(dataIn));
	epc_eprom_model #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) epc_eprom_model_i (
		.pins(pins), .dataIn(dataIn));
	initial forever #12.5 mclk = ~mclk;
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		cmp(rd & m, e);
		cmp({31'h0, hresp}, 32'h0);
	endtask
	task automatic irqIs(input logic e);
		repeat (2) @(negedge mclk);
		cmp({31'h0, irq}, {31'h0, e});
		@(posedge mclk);
	endtask
	task automatic start(input epc_cmd_e c, input logic [17:0] a, input logic [7:0] d);
		bus(`EPC_OFF_ADDR, 1'b1, {14'h0, a});
		bus(`EPC_OFF_WDATA, 1'b1, {24'h0, d});
		bus(`EPC_OFF_CTRL, 1'b1, {29'h0, c, 1'b1});
	endtask
	task automatic waitIdle;
		int n;
		n = 0;
		do begin
			bus(`EPC_OFF_STATUS, 1'b0, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 30000);
		if (rd[0] !== 1'b0) begin
			n_errors++;
			$display("CHECK FAILED at %0t: operation never finished", $time);
		end
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge mclk);
		n_errors++;
		complete_run;
	end
	initial begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(`EPC_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
		chk(`EPC_OFF_IRQMASK, 32'hFFFFFFFF, 32'h0);
		chk(8'h20, 32'hFFFFFFFF, 32'h0);
		start(CMD_READ, 18'h00123, 8'h00);
		waitIdle;
		chk(`EPC_OFF_RDATA, 32'hFFFFFFFF, 32'hFF);
		irqIs(1'b0);
		bus(`EPC_OFF_IRQMASK, 1'b1, 32'h3);
		irqIs(1'b1);
		bus(`EPC_OFF_IRQSTAT, 1'b1, 32'h1);
		irqIs(1'b0);
		start(CMD_PROGRAM, 18'h00123, 8'h3C);
		waitIdle;
		chk(`EPC_OFF_STATUS, 32'hF3, 32'h10);
		start(CMD_VERIFY, 18'h00123, 8'h3C);
		waitIdle;
		chk(`EPC_OFF_STATUS, 32'h2, 32'h0);
		start(CMD_READ, 18'h00123, 8'h00);
		waitIdle;
		chk(`EPC_OFF_RDATA, 32'hFF, 32'h3C);
		for (int i = 0; i < 2; i++) begin
			start(CMD_SIGNATURE, 18'(i), 8'h00);
			waitIdle;
			chk(`EPC_OFF_RDATA, 32'hFF, {24'h0, i ? PART_CODE : MAKER_CODE});
		end
		start(CMD_PROGRAM, 18'h20042, 8'h5A);
		waitIdle;
		chk(`EPC_OFF_RDATA, 32'hFF, 32'h5A);
		start(CMD_READ, 18'h00123, 8'h00);
		waitIdle;
		chk(`EPC_OFF_RDATA, 32'hFF, 32'h3C);
		start(CMD_PROGRAM, 18'h00123, 8'hF0);
		bus(`EPC_OFF_ADDR, 1'b1, 32'h777);
		waitIdle;
		chk(`EPC_OFF_STATUS, 32'hF3, 32'hA2);
		chk(`EPC_OFF_FAILADDR, 32'h3FFFF, 32'h123);
		chk(`EPC_OFF_ADDR, 32'h3FFFF, 32'h123);
		chk(`EPC_OFF_IRQSTAT, 32'h2, 32'h2);
		irqIs(1'b1);
		complete_run;
	end
endmodule
`default_nettype wire
